// ==== verilog/edu_pkg.sv ====
`default_nettype none
package edu_pkg;
  // ==========================================================
  // operating modes and fixed vectors
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_PROT = 2'h1;
  localparam logic [1:0] MODE_LONG = 2'h2;
  localparam logic [7:0] VEC_BK = 8'h03;
  localparam logic [7:0] VEC_OV = 8'h04;
  localparam logic [7:0] VEC_RG = 8'h05;
  localparam logic [7:0] VEC_FE = 8'h10;
  localparam logic [7:0] VEC_SX = 8'h13;
  localparam int FP_COND_W = 6;
  localparam int OV_BIT = 11;
  localparam int IF_BIT = 9;
  localparam int TBL_SHIFT = 2;
  localparam int PUSH_SLOTS = 6;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TBL_BASE = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [1:0] CTRL_RST = MODE_REAL;
  localparam logic [31:0] TBL_BASE_RST = 32'h0000_0000;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_VEC_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    EV_EXT = 3'h0, EV_SOFT = 3'h1, EV_OVF = 3'h2, EV_BREAK = 3'h3,
    EV_RANGE = 3'h4, EV_FP_LEG = 3'h5, EV_FP_PKD = 3'h6, EV_ARITH = 3'h7
  } edu_event_type;
  typedef enum logic [1:0] {GATE_INT = 2'h0, GATE_TRAP = 2'h1, GATE_TASK = 2'h2} edu_gate_type;
  typedef enum logic [1:0] {DK_FAR = 2'h0, DK_GATE = 2'h1, DK_TASK = 2'h2} edu_disp_kind_type;
  typedef struct packed {
    edu_event_type ev;
    logic [7:0] vector;
    edu_gate_type gate;
    logic has_err;
    logic [31:0] err_code;
    logic [31:0] flags;
    logic [15:0] cs;
    logic [63:0] ip;
    logic [15:0] ss;
    logic [63:0] sp;
    logic pl_change;
    logic is_mgmt;
    logic [15:0] tgt_cs;
    logic [63:0] tgt_ip;
    logic [31:0] operand;
    logic [31:0] lower;
    logic [31:0] upper;
    logic [FP_COND_W-1:0] fp_cond;
  } edu_req_type;
  typedef struct packed {
    logic [7:0] vector;
    edu_disp_kind_type kind;
    logic [15:0] new_cs;
    logic [63:0] new_ip;
    logic [31:0] new_flags;
    logic load_ss;
    logic [15:0] new_ss;
    logic code64;
  } edu_disp_type;
  typedef struct packed {
    logic [63:0] data;
    logic size8;
  } edu_push_type;
endpackage
`default_nettype wire

// ==== verilog/edu_dispatch.sv ====
// How it works
// [RULE_01] task gate vector dispatches as task call
// [RULE_02] task dispatch saves interrupted task state
// [RULE_03] task return restores state and resumes
// [RULE_04] real mode reads handler from vector table
// [RULE_05] real mode pushes flags, cs, ip, error
// [RULE_06] return instruction ends real mode handler
// [RULE_07] soft interrupt invokes any supplied vector
// [RULE_08] overflow call traps only with overflow set
// [RULE_09] arithmetic overflow never traps by itself
// [RULE_10] breakpoint always invokes breakpoint trap
// [RULE_11] range check traps only when out of bounds
// [RULE_12] range trap never raised implicitly
// [RULE_13] six floating-point conditions are recognised
// [RULE_14] legacy fp conditions raise fp error trap
// [RULE_15] packed fp conditions raise simd trap
// [RULE_16] long mode handlers are 64-bit, except mgmt
// [RULE_17] long mode pushes are zero-extended 8 bytes
// [RULE_18] long mode always pushes ss and sp
// [RULE_19] long mode privilege change loads null ss
// [RULE_20] interrupt gate clears if, trap keeps it
// [RULE_21] push order flags, cs, ip without switch
// [RULE_22] error code pushed last, lowest address
`timescale 1ns/1ns
`default_nettype none
module edu_dispatch (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic req_valid_i,
  input wire edu_pkg::edu_req_type req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic done_taken_o,
  input wire logic ret_valid_i,
  input wire logic ret_task_i,
  output logic resume_o,
  output logic resume_task_o,
  output logic tbl_rd_o,
  output logic [31:0] tbl_addr_o,
  input wire logic tbl_rvalid_i,
  input wire logic [31:0] tbl_rdata_i,
  output logic task_save_o,
  output logic task_restore_o,
  input wire logic task_done_i,
  output logic push_valid_o,
  output edu_pkg::edu_push_type push_o,
  input wire logic push_ready_i,
  output logic disp_valid_o,
  output edu_pkg::edu_disp_type disp_o
);
  import edu_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_TBL = 3'h1, ST_SAVE = 3'h2, ST_PUSH = 3'h3,
    ST_DISP = 3'h4, ST_RESTORE = 3'h5, ST_RET = 3'h6
  } edu_state_type;

  // ==========================================================
  // helpers
  function automatic logic [8:0] trap_of(input edu_req_type r);
    logic [8:0] t;
    t = 9'h000;
    case (r.ev)
      EV_EXT: t = {1'b1, r.vector};
      EV_SOFT: t = {1'b1, r.vector}; // RULE_07
      EV_OVF: t = {r.flags[OV_BIT], VEC_OV}; // RULE_08
      EV_BREAK: t = {1'b1, VEC_BK}; // RULE_10
      EV_RANGE: t = {($signed(r.operand) < $signed(r.lower)) ||
                     ($signed(r.operand) > $signed(r.upper)), VEC_RG}; // RULE_11
      EV_FP_LEG: t = {|r.fp_cond, VEC_FE}; // RULE_14
      EV_FP_PKD: t = {|r.fp_cond, VEC_SX}; // RULE_15
      default: t = 9'h000; // RULE_09
    endcase
    return t;
  endfunction

  function automatic logic [2:0] low_slot(input logic [PUSH_SLOTS-1:0] m);
    logic [2:0] s;
    s = 3'h0;
    for (int i = PUSH_SLOTS - 1; i >= 0; i--) begin
      if (m[i]) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [63:0] push_word(input logic [2:0] s, input edu_req_type r,
                                            input logic wide);
    logic [63:0] w;
    w = 64'h0;
    case (s)
      3'h0: w = {48'h0, r.ss};
      3'h1: w = wide ? r.sp : {32'h0, r.sp[31:0]};
      3'h2: w = {32'h0, r.flags};
      3'h3: w = {48'h0, r.cs};
      3'h4: w = wide ? r.ip : {32'h0, r.ip[31:0]};
      3'h5: w = {32'h0, r.err_code};
      default: w = 64'h0;
    endcase
    return w;
  endfunction

  // ==========================================================
  // register bus
  logic [1:0] mode_ff;
  logic [31:0] tbl_base_ff;
  logic [31:0] count_ff;
  logic [FP_COND_W-1:0] fp_seen_ff;
  logic [7:0] last_vec_ff;
  logic [31:0] hrdata_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  edu_state_type state_ff;
  edu_state_type nxt_state;
  logic addr_phase;
  logic [7:0] reg_addr;
  logic [31:0] rd_val;
  logic wr_status;
  logic wr_count;

  assign addr_phase = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == 2'h3);
  assign reg_addr = haddr_i[7:0];
  assign wr_status = wr_pend_ff && wr_addr_ff == REG_STATUS;
  assign wr_count = wr_pend_ff && wr_addr_ff == REG_COUNT;

  always_comb begin
    rd_val = 32'h0;
    if (haddr_i[31:8] == 24'h0) begin
      case (reg_addr)
        REG_CTRL: rd_val = {30'h0, mode_ff};
        REG_STATUS: rd_val = {16'h0, last_vec_ff, 1'b0, state_ff != ST_IDLE, fp_seen_ff};
        REG_TBL_BASE: rd_val = tbl_base_ff;
        REG_COUNT: rd_val = count_ff;
        default: rd_val = 32'h0;
      endcase
    end
  end

  // zero wait states: read data is sampled in the address phase
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hrdata_ff <= 32'h0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase && hwrite_i && hsize_i == HSIZE_WORD && haddr_i[31:8] == 24'h0;
      wr_addr_ff <= reg_addr;
      if (addr_phase && !hwrite_i) begin
        hrdata_ff <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_ff <= CTRL_RST;
      tbl_base_ff <= TBL_BASE_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == REG_CTRL) begin
        mode_ff <= hwdata_i[1:0];
      end
      if (wr_addr_ff == REG_TBL_BASE) begin
        tbl_base_ff <= hwdata_i;
      end
    end
  end

  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ==========================================================
  // event acceptance
  logic ready_ff;
  logic accept;
  logic ret_take;
  logic [8:0] trap;
  logic is_real;
  logic is_long;
  edu_req_type req_ff;
  logic [7:0] cur_vec_ff;
  logic [31:0] entry_ff;
  logic [PUSH_SLOTS-1:0] mask_ff;
  logic [PUSH_SLOTS-1:0] nxt_mask;
  logic done_ff;
  logic done_taken_ff;

  assign accept = req_valid_i && ready_ff;
  assign ret_take = ret_valid_i && ready_ff && !req_valid_i;
  assign trap = trap_of(req_i); // RULE_12
  assign is_real = mode_ff == MODE_REAL;
  assign is_long = mode_ff == MODE_LONG;

  always_comb begin
    nxt_mask = 6'h00;
    nxt_mask[2] = 1'b1; // RULE_21
    nxt_mask[3] = 1'b1;
    nxt_mask[4] = 1'b1;
    nxt_mask[5] = req_i.has_err; // RULE_22
    nxt_mask[0] = !is_real && (is_long || req_i.pl_change); // RULE_18
    nxt_mask[1] = nxt_mask[0];
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      req_ff <= '0;
      cur_vec_ff <= 8'h00;
      done_ff <= 1'b0;
      done_taken_ff <= 1'b0;
    end else begin
      done_ff <= accept;
      done_taken_ff <= accept && trap[8];
      if (accept) begin
        req_ff <= req_i;
        cur_vec_ff <= trap[7:0];
      end
    end
  end

  // status: sticky fp conditions, set wins over write-one-to-clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fp_seen_ff <= 6'h00;
      last_vec_ff <= 8'h00;
      count_ff <= 32'h0;
    end else begin
      fp_seen_ff <= (fp_seen_ff & ~(wr_status ? hwdata_i[5:0] : 6'h00)) |
                    ((accept && (req_i.ev == EV_FP_LEG || req_i.ev == EV_FP_PKD)) ?
                     req_i.fp_cond : 6'h00); // RULE_13
      if (accept && trap[8]) begin
        last_vec_ff <= trap[7:0];
      end
      if (state_ff == ST_DISP) begin
        count_ff <= wr_count ? 32'h1 : count_ff + 32'h1;
      end else if (wr_count) begin
        count_ff <= 32'h0;
      end
    end
  end

  // ==========================================================
  // dispatch sequencer
  logic push_last;
  assign push_last = push_valid_o && push_ready_i &&
                     (mask_ff & ~(6'h01 << low_slot(mask_ff))) == 6'h00;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept && trap[8]) begin
          if (is_real) begin
            nxt_state = ST_TBL; // RULE_04
          end else if (req_i.gate == GATE_TASK) begin
            nxt_state = ST_SAVE; // RULE_01
          end else begin
            nxt_state = ST_PUSH;
          end
        end else if (ret_take) begin
          nxt_state = ret_task_i ? ST_RESTORE : ST_RET; // RULE_06
        end
      end
      ST_TBL: nxt_state = tbl_rvalid_i ? ST_PUSH : ST_TBL;
      ST_SAVE: nxt_state = task_done_i ? ST_DISP : ST_SAVE;
      ST_PUSH: nxt_state = push_last ? ST_DISP : ST_PUSH;
      ST_DISP: nxt_state = ST_IDLE;
      ST_RESTORE: nxt_state = task_done_i ? ST_RET : ST_RESTORE; // RULE_03
      ST_RET: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= nxt_state == ST_IDLE;
    end
  end

  // table read and task save/restore handshakes
  logic tbl_rd_ff;
  logic [31:0] tbl_addr_ff;
  logic task_save_ff;
  logic task_restore_ff;
  logic resume_ff;
  logic resume_task_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tbl_rd_ff <= 1'b0;
      tbl_addr_ff <= 32'h0;
      entry_ff <= 32'h0;
      task_save_ff <= 1'b0;
      task_restore_ff <= 1'b0;
      resume_ff <= 1'b0;
      resume_task_ff <= 1'b0;
    end else begin
      tbl_rd_ff <= state_ff == ST_IDLE && nxt_state == ST_TBL;
      if (state_ff == ST_IDLE && nxt_state == ST_TBL) begin
        tbl_addr_ff <= tbl_base_ff + ({24'h0, trap[7:0]} << TBL_SHIFT); // RULE_04
      end
      if (state_ff == ST_TBL && tbl_rvalid_i) begin
        entry_ff <= tbl_rdata_i;
      end
      task_save_ff <= nxt_state == ST_SAVE; // RULE_02
      task_restore_ff <= nxt_state == ST_RESTORE; // RULE_03
      resume_ff <= nxt_state == ST_RET;
      if (ret_take) begin
        resume_task_ff <= ret_task_i;
      end
    end
  end

  // stack pushes: one word at a time, lowest slot first
  logic push_valid_ff;
  edu_push_type push_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mask_ff <= 6'h00;
      push_valid_ff <= 1'b0;
      push_ff <= '0;
    end else begin
      if (accept && trap[8]) begin
        mask_ff <= nxt_mask; // RULE_05
      end else if (push_valid_ff && push_ready_i) begin
        mask_ff <= mask_ff & ~(6'h01 << low_slot(mask_ff));
      end
      if (state_ff == ST_PUSH && !push_valid_ff) begin
        push_valid_ff <= 1'b1;
        push_ff.data <= push_word(low_slot(mask_ff), req_ff, is_long); // RULE_17
        push_ff.size8 <= is_long;
      end else if (push_valid_ff && push_ready_i) begin
        push_valid_ff <= 1'b0;
      end
    end
  end

  // handler entry
  logic disp_valid_ff;
  edu_disp_type disp_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      disp_valid_ff <= 1'b0;
      disp_ff <= '0;
    end else begin
      disp_valid_ff <= nxt_state == ST_DISP;
      if (nxt_state == ST_DISP) begin
        disp_ff.vector <= cur_vec_ff;
        disp_ff.kind <= is_real ? DK_FAR : (req_ff.gate == GATE_TASK ? DK_TASK : DK_GATE);
        disp_ff.new_cs <= is_real ? entry_ff[31:16] : req_ff.tgt_cs;
        disp_ff.new_ip <= is_real ? {48'h0, entry_ff[15:0]} : req_ff.tgt_ip;
        disp_ff.new_flags <= req_ff.flags;
        if (is_real || req_ff.gate == GATE_INT) begin
          disp_ff.new_flags[IF_BIT] <= 1'b0; // RULE_20
        end
        disp_ff.load_ss <= is_long && req_ff.pl_change; // RULE_19
        disp_ff.new_ss <= 16'h0000;
        disp_ff.code64 <= is_long && !req_ff.is_mgmt; // RULE_16
      end
    end
  end

  assign req_ready_o = ready_ff;
  assign done_o = done_ff;
  assign done_taken_o = done_taken_ff;
  assign resume_o = resume_ff;
  assign resume_task_o = resume_task_ff;
  assign tbl_rd_o = tbl_rd_ff;
  assign tbl_addr_o = tbl_addr_ff;
  assign task_save_o = task_save_ff;
  assign task_restore_o = task_restore_ff;
  assign push_valid_o = push_valid_ff;
  assign push_o = push_ff;
  assign disp_valid_o = disp_valid_ff;
  assign disp_o = disp_ff;

  // ==========================================================
  // checks
  property p_ovf_quiet;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && req_i.ev == EV_OVF && !req_i.flags[OV_BIT] |=> done_o && !done_taken_o;
  endproperty
  a_ovf_quiet: assert property (p_ovf_quiet) else $error("overflow call trapped"); // RULE_08
  property p_arith_quiet;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && req_i.ev == EV_ARITH |=> done_o && !done_taken_o ##1 state_ff == ST_IDLE;
  endproperty
  a_arith_quiet: assert property (p_arith_quiet) else $error("arith trapped"); // RULE_09
  property p_bk_vec;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && req_i.ev == EV_BREAK |=> done_taken_o && cur_vec_ff == VEC_BK;
  endproperty
  a_bk_vec: assert property (p_bk_vec) else $error("breakpoint vector wrong"); // RULE_10
  property p_range_in;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && req_i.ev == EV_RANGE && $signed(req_i.operand) >= $signed(req_i.lower) &&
    $signed(req_i.operand) <= $signed(req_i.upper) |=> !done_taken_o;
  endproperty
  a_range_in: assert property (p_range_in) else $error("range trap in bounds"); // RULE_11
  property p_simd_route;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && req_i.ev == EV_FP_PKD && req_i.fp_cond != 6'h00 |=> cur_vec_ff == VEC_SX;
  endproperty
  a_simd_route: assert property (p_simd_route) else $error("packed fp misrouted"); // RULE_15
  property p_wide_push;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    push_valid_o && mode_ff == MODE_LONG |-> push_o.size8;
  endproperty
  a_wide_push: assert property (p_wide_push) else $error("narrow push in long mode"); // RULE_17
  property p_if_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    disp_valid_o && disp_o.kind == DK_GATE && req_ff.gate == GATE_INT |->
    !disp_o.new_flags[IF_BIT];
  endproperty
  a_if_clear: assert property (p_if_clear) else $error("if kept on interrupt gate"); // RULE_20
  property p_null_ss;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    disp_valid_o && mode_ff == MODE_LONG && req_ff.pl_change |->
    disp_o.load_ss && disp_o.new_ss == 16'h0000;
  endproperty
  a_null_ss: assert property (p_null_ss) else $error("ss not null"); // RULE_19
  property p_real_tbl;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    accept && trap[8] && mode_ff == MODE_REAL |=> tbl_rd_o ##1 !tbl_rd_o;
  endproperty
  a_real_tbl: assert property (p_real_tbl) else $error("no table read"); // RULE_04
  c_task: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) task_save_o ##1 disp_valid_o);
  c_real: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    disp_valid_o && disp_o.kind == DK_FAR);
  c_long: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    disp_valid_o && disp_o.code64 && disp_o.load_ss);
  c_ret: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) task_restore_o ##1 resume_o);
endmodule
`default_nettype wire

// ==== sim/edu_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// core and stack stand-in: random stalls, table entries derived from address
module edu_core_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic tbl_rd_i,
  input wire logic [31:0] tbl_addr_i,
  output logic tbl_rvalid_o,
  output logic [31:0] tbl_rdata_o,
  input wire logic task_save_i,
  input wire logic task_restore_i,
  output logic task_done_o,
  output logic push_ready_o
);
  int seed = 32'h853A0413;
  logic [31:0] addr_ff;
  logic [2:0] tbl_wait_ff;
  logic [2:0] task_wait_ff;
  logic tbl_busy_ff;
  initial begin
    tbl_rvalid_o = 1'b0;
    tbl_rdata_o = 32'h0;
    task_done_o = 1'b0;
    push_ready_o = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    // stack stalls about one cycle in four
    push_ready_o <= ($random(seed) & 3) != 0;
    tbl_rvalid_o <= 1'b0;
    task_done_o <= 1'b0;
    // outside a valid beat the data lines toggle, holding the old entry every other cycle
    tbl_rdata_o <= ~tbl_rdata_o;
    if (!rst_n_i) begin
      tbl_busy_ff <= 1'b0;
      tbl_wait_ff <= 3'h0;
      task_wait_ff <= 3'h0;
    end else begin
      if (tbl_rd_i) begin
        tbl_busy_ff <= 1'b1;
        addr_ff <= tbl_addr_i;
        tbl_wait_ff <= 3'($random(seed));
      end else if (tbl_busy_ff && tbl_wait_ff == 3'h0) begin
        tbl_busy_ff <= 1'b0;
        tbl_rvalid_o <= 1'b1;
        tbl_rdata_o <= {addr_ff[15:0] ^ 16'hC3A5, addr_ff[15:0] ^ 16'h5A3C};
      end else if (tbl_busy_ff) begin
        tbl_wait_ff <= tbl_wait_ff - 3'h1;
      end
      // task save or restore finishes after a random delay
      if ((task_save_i || task_restore_i) && !task_done_o) begin
        if (task_wait_ff == 3'h0) begin
          task_done_o <= 1'b1;
          task_wait_ff <= 3'($random(seed));
        end else begin
          task_wait_ff <= task_wait_ff - 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/edu_dispatch_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module edu_dispatch_bench;
  import edu_pkg::*;
  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic rst_n, hsel, hwrite, hready, req_valid, ret_valid, ret_task;
  logic [31:0] haddr, hwdata, hrdata, tbl_addr, tbl_rdata, tbl_base, st;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic hreadyout, hresp, req_ready, done, done_taken, resume, resume_task;
  logic tbl_rd, tbl_rvalid, task_save, task_restore, task_done;
  logic push_valid, push_ready, disp_valid, saw_task;
  edu_req_type req, r;
  edu_push_type push;
  edu_disp_type disp;
  edu_push_type pushq[$];
  int seed = 32'h853A0413;
  int num_errors = 0;
  int n_tests = 0;
  assign hready = hreadyout;
  always #2 ref_clk = ~ref_clk;
  edu_dispatch edu_dispatch_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
    .done_o(done), .done_taken_o(done_taken), .ret_valid_i(ret_valid),
    .ret_task_i(ret_task), .resume_o(resume), .resume_task_o(resume_task),
    .tbl_rd_o(tbl_rd), .tbl_addr_o(tbl_addr), .tbl_rvalid_i(tbl_rvalid),
    .tbl_rdata_i(tbl_rdata), .task_save_o(task_save), .task_restore_o(task_restore),
    .task_done_i(task_done), .push_valid_o(push_valid), .push_o(push),
    .push_ready_i(push_ready), .disp_valid_o(disp_valid), .disp_o(disp));
  edu_core_model edu_core_model_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .tbl_rd_i(tbl_rd),
    .tbl_addr_i(tbl_addr), .tbl_rvalid_o(tbl_rvalid), .tbl_rdata_o(tbl_rdata),
    .task_save_i(task_save), .task_restore_i(task_restore), .task_done_o(task_done),
    .push_ready_o(push_ready));
  always @(posedge ref_clk) begin
    if (push_valid === 1'b1 && push_ready === 1'b1) pushq.push_back(push);
    if (task_save === 1'b1 || task_restore === 1'b1) saw_task <= 1'b1;
  end
  // ==========================================================
  // helpers
  task automatic test_done;
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] exp_vec(input edu_req_type q);
    case (q.ev)
      EV_EXT, EV_SOFT: return {1'b1, q.vector};
      EV_OVF: return {q.flags[OV_BIT], VEC_OV};
      EV_BREAK: return {1'b1, VEC_BK};
      EV_RANGE: return {($signed(q.operand) < $signed(q.lower)) ||
        ($signed(q.operand) > $signed(q.upper)), VEC_RG};
      EV_FP_LEG: return {q.fp_cond != 6'h0, VEC_FE};
      EV_FP_PKD: return {q.fp_cond != 6'h0, VEC_SX};
      default: return 9'h0;
    endcase
  endfunction
  function automatic edu_push_type pw(input logic [63:0] d, input logic lng);
    return {lng ? d : {32'h0, d[31:0]}, lng};
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic mk(input edu_event_type e, input edu_gate_type g);
    r = '0;
    r.ev = e;
    r.gate = g;
    r.vector = 8'($random(seed));
    r.has_err = 1'($random(seed));
    r.err_code = $random(seed);
    r.flags = $random(seed);
    r.cs = 16'($random(seed));
    r.ip = {(mode == MODE_LONG) ? 32'($random(seed)) : 32'h0, 32'($random(seed))};
    r.ss = 16'($random(seed));
    r.sp = {32'($random(seed)), 32'($random(seed))};
    r.tgt_cs = 16'($random(seed));
    r.tgt_ip = {32'($random(seed)), 32'($random(seed))};
    r.lower = $random(seed) & 32'h0FFF_FFFF;
    r.upper = r.lower + 32'h10;
    r.operand = r.lower - 32'h1;
    r.fp_cond = 6'($random(seed)) | 6'h01;
    r.pl_change = (mode != MODE_REAL) && 1'($random(seed));
  endtask
  // ==========================================================
  // one event from request to dispatch
  task automatic run_ev;
    logic [8:0] v;
    logic lng, tsk;
    logic [31:0] ent, nf;
    edu_push_type q[$];
    int i;
    v = exp_vec(r);
    lng = (mode == MODE_LONG);
    tsk = (mode != MODE_REAL) && (r.gate == GATE_TASK);
    ent = tbl_base + {22'h0, v[7:0], 2'h0};
    ent = {ent[15:0] ^ 16'hC3A5, ent[15:0] ^ 16'h5A3C};
    nf = (mode == MODE_REAL || r.gate == GATE_INT) ? r.flags & ~(32'h1 << IF_BIT) : r.flags;
    pushq.delete();
    saw_task = 1'b0;
    req <= r;
    req_valid <= 1'b1;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    @(posedge ref_clk);
    chk(done, 1'b1);
    chk(done_taken, v[8]);
    if (mode == MODE_REAL && v[8]) begin
      chk(tbl_rd, 1'b1);
      chk(tbl_addr, tbl_base + {22'h0, v[7:0], 2'h0});
    end
    i = 0;
    while (disp_valid !== 1'b1 && i < 100) begin
      @(posedge ref_clk);
      i++;
    end
    chk(disp_valid, v[8]);
    if (v[8] && !tsk) begin
      if (lng || (mode == MODE_PROT && r.pl_change)) begin
        q.push_back(pw({48'h0, r.ss}, lng));
        q.push_back(pw(r.sp, lng));
      end
      q.push_back(pw({32'h0, r.flags}, lng));
      q.push_back(pw({48'h0, r.cs}, lng));
      q.push_back(pw(r.ip, lng));
      if (r.has_err) q.push_back(pw({32'h0, r.err_code}, lng));
    end
    chk(pushq.size(), q.size());
    foreach (q[j]) chk(pushq[j], q[j]);
    if (v[8]) begin
      chk(disp.vector, v[7:0]);
      chk(disp.kind, tsk ? DK_TASK : (mode == MODE_REAL) ? DK_FAR : DK_GATE);
      chk(saw_task, tsk);
      if (!tsk) begin
        chk(disp.new_cs, (mode == MODE_REAL) ? ent[31:16] : r.tgt_cs);
        chk(disp.new_ip, (mode == MODE_REAL) ? {48'h0, ent[15:0]} : r.tgt_ip);
        chk(disp.new_flags, nf);
        chk(disp.code64, lng && !r.is_mgmt);
        chk(disp.load_ss, lng && r.pl_change);
        if (lng && r.pl_change) chk(disp.new_ss, 16'h0);
      end
    end
  endtask
  task automatic ret(input logic t);
    int i;
    saw_task = 1'b0;
    ret_valid <= 1'b1;
    ret_task <= t;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    ret_valid <= 1'b0;
    i = 0;
    while (resume !== 1'b1 && i < 100) begin
      @(posedge ref_clk);
      i++;
    end
    chk(resume, 1'b1);
    chk(resume_task, t);
    chk(saw_task, t);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    // a hung handshake lands here instead of running forever
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    test_done;
  end
  initial begin
    rst_n <= 1'b0;
    {hsel, hwrite, req_valid, ret_valid, ret_task} <= 5'h0;
    {haddr, hwdata} <= 64'h0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    req <= '0;
    mode = MODE_REAL;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, {24'h0, REG_CTRL}, 32'h0, st);
    chk(st[1:0], MODE_REAL);
    bus(1'b0, 32'h0000_0100, 32'h0, st);
    chk(st, 32'h0);
    tbl_base = $random(seed) & 32'hFFFF_FF00;
    bus(1'b1, {24'h0, REG_TBL_BASE}, tbl_base, st);
    bus(1'b0, {24'h0, REG_TBL_BASE}, 32'h0, st);
    chk(st, tbl_base);
    for (int e = 0; e < 7; e++) begin
      mk(edu_event_type'(e), GATE_INT);
      r.flags[OV_BIT] = 1'b1;
      run_ev;
      ret(1'b0);
    end
    // corner cases that must not trap
    mk(EV_OVF, GATE_INT);
    r.flags[OV_BIT] = 1'b0;
    run_ev;
    mk(EV_ARITH, GATE_INT);
    r.flags[OV_BIT] = 1'b1;
    run_ev;
    mk(EV_RANGE, GATE_INT);
    r.operand = r.upper;
    run_ev;
    mk(EV_RANGE, GATE_INT);
    r.operand = r.lower;
    run_ev;
    mk(EV_FP_PKD, GATE_INT);
    r.fp_cond = 6'h0;
    run_ev;
    for (int m = 1; m < 3; m++) begin
      mode = 2'(m);
      bus(1'b1, {24'h0, REG_CTRL}, {30'h0, mode}, st);
      for (int g = 0; g < 4; g++) begin
        mk(EV_SOFT, (mode == MODE_PROT) ? edu_gate_type'(g % 3) : edu_gate_type'(g & 1));
        r.pl_change = g[0];
        r.is_mgmt = (mode == MODE_LONG) && g[1];
        run_ev;
        ret(r.gate == GATE_TASK && mode == MODE_PROT);
      end
    end
    // sticky conditions on three of the six flags, after a write-one clears all six
    bus(1'b1, {24'h0, REG_STATUS}, 32'h0000_003F, st);
    mk(EV_FP_LEG, GATE_TRAP);
    r.fp_cond = 6'h2A;
    run_ev;
    bus(1'b0, {24'h0, REG_STATUS}, 32'h0, st);
    chk(st[5:0], 6'h2A);
    chk(st[15:8], VEC_FE);
    bus(1'b0, {24'h0, REG_COUNT}, 32'h0, st);
    chk({hresp, st}, 33'h10);
    test_done;
  end
endmodule
`default_nettype wire
